/* File: bce_top.sv */
// block cipher engine: AXI4-Lite register front end, key and state memories
// assumes a single AXI4-Lite master with at most one write and one read outstanding
`timescale 1ns/1ps
`default_nettype none
module bce_top (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic o_irq,
  output logic o_dma_trig
);

  bce_core_if cif ();

  logic awready_r;
  logic wready_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [4:0] ctrl_r;
  logic done_flag_r;
  logic start_r;
  logic irq_r;
  logic dma_trig_r;
  logic [7:0] st_mem_r [16];
  logic [7:0] key_mem_r [16];
  logic wr_fire;
  logic busy;
  logic start_nxt;
  logic [31:0] rd_data;
  logic rd_err;

  ////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write paths
  function automatic logic in_state(input logic [7:0] a);
    in_state = (a[7:4] == bce_pkg::OFF_STATE0[7:4]);
  endfunction : in_state

  function automatic logic in_key(input logic [7:0] a);
    in_key = (a[7:4] == bce_pkg::OFF_KEY0[7:4]);
  endfunction : in_key

  ////////////////////////////////////////////////////////////////////////
  // write channels: address and data taken in either order
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign busy = cif.busy || start_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (i_s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b1;
      aw_addr_r <= i_s_axi_awaddr;
    end else begin
      if (wr_fire) aw_held_r <= 1'b0;
      if (!aw_held_r && !bvalid_r) awready_r <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (i_s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b1;
      wdata_r <= i_s_axi_wdata;
      wstrb_r <= i_s_axi_wstrb;
    end else begin
      if (wr_fire) w_held_r <= 1'b0;
      if (!w_held_r && !bvalid_r) wready_r <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= bce_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= (aw_addr_r == bce_pkg::OFF_CTRL || aw_addr_r == bce_pkg::OFF_STATUS ||
                  in_state(aw_addr_r) || in_key(aw_addr_r)) && aw_addr_r[1:0] == 2'b00
                 ? bce_pkg::RESP_OKAY : bce_pkg::RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and start requests
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctrl_r <= bce_pkg::CTRL_RESET;
    end else if (wr_fire && aw_addr_r == bce_pkg::OFF_CTRL && wstrb_r[0]) begin
      ctrl_r <= {wdata_r[4:1], 1'b0};
    end
  end

  // a start while busy is dropped; the loaded memories are the caller's job
  always_comb begin
    start_nxt = 1'b0;
    if (wr_fire && !busy) begin
      if (aw_addr_r == bce_pkg::OFF_CTRL && wstrb_r[0] && wdata_r[bce_pkg::CTRL_START]) begin
        start_nxt = 1'b1;
      end
      if (ctrl_r[bce_pkg::CTRL_AUTO] && aw_addr_r == bce_pkg::OFF_STATE3 && wstrb_r[3]) begin
        start_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      start_r <= 1'b0;
    end else begin
      start_r <= start_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // key and state memories; software writes are ignored while busy
  for (genvar i = 0; i < 16; i++) begin : g_mem
    always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
        st_mem_r[i] <= 8'h00;
        key_mem_r[i] <= 8'h00;
      end else if (cif.done) begin
        st_mem_r[i] <= bce_pkg::byte_of(cif.dout, i);
      end else if (wr_fire && !busy && aw_addr_r[3:0] == 4'(4 * (i / 4)) && wstrb_r[i % 4]) begin
        if (in_state(aw_addr_r)) begin
          st_mem_r[i] <= ctrl_r[bce_pkg::CTRL_XOR]
                         ? st_mem_r[i] ^ wdata_r[8 * (i % 4) +: 8]
                         : wdata_r[8 * (i % 4) +: 8];
        end
        if (in_key(aw_addr_r)) key_mem_r[i] <= wdata_r[8 * (i % 4) +: 8];
      end
    end
    assign cif.din[127 - 8 * i -: 8] = st_mem_r[i];
    assign cif.key[127 - 8 * i -: 8] = key_mem_r[i];
  end

  assign cif.start = start_r;
  assign cif.decrypt = ctrl_r[bce_pkg::CTRL_DECRYPT];

  bce_core u_core (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .bus(cif)
  );

  ////////////////////////////////////////////////////////////////////////
  // completion: flag, interrupt and DMA trigger
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      done_flag_r <= 1'b0;
    end else if (cif.done) begin
      done_flag_r <= 1'b1;
    end else if (start_r) begin
      done_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_r <= 1'b0;
      dma_trig_r <= 1'b0;
    end else begin
      // level request held until the next start or until disabled
      irq_r <= ctrl_r[bce_pkg::CTRL_IRQ_EN] && (cif.done || (done_flag_r && !start_r));
      dma_trig_r <= cif.done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path; state reads as zero while an operation runs
  always_comb begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (i_s_axi_araddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end else if (i_s_axi_araddr == bce_pkg::OFF_CTRL) begin
      rd_data = {27'h0000000, ctrl_r};
    end else if (i_s_axi_araddr == bce_pkg::OFF_STATUS) begin
      rd_data[bce_pkg::STAT_DONE] = done_flag_r;
      rd_data[bce_pkg::STAT_BUSY] = busy;
    end else if (in_state(i_s_axi_araddr)) begin
      if (!busy) begin
        for (int j = 0; j < 4; j++) begin
          rd_data[8 * j +: 8] = st_mem_r[{i_s_axi_araddr[3:2], 2'(j)}];
        end
      end
    end else if (in_key(i_s_axi_araddr)) begin
      for (int j = 0; j < 4; j++) begin
        rd_data[8 * j +: 8] = key_mem_r[{i_s_axi_araddr[3:2], 2'(j)}];
      end
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= bce_pkg::RESP_OKAY;
    end else if (i_s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_err ? bce_pkg::RESP_SLVERR : bce_pkg::RESP_OKAY;
    end else begin
      if (rvalid_r && i_s_axi_rready) rvalid_r <= 1'b0;
      if (!rvalid_r && !arready_r) arready_r <= 1'b1;
    end
  end

  assign o_s_axi_awready = awready_r;
  assign o_s_axi_wready = wready_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_arready = arready_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = rresp_r;
  assign o_irq = irq_r;
  assign o_dma_trig = dma_trig_r;

endmodule : bce_top
`default_nettype wire

/* File: bce_pkg.sv */
// block cipher engine: constants, register map and cipher arithmetic
// assumes an AXI4-Lite slave with byte addresses and 32-bit data
package bce_pkg;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_STATE0 = 8'h10;
  localparam logic [7:0] OFF_STATE3 = 8'h1c;
  localparam logic [7:0] OFF_KEY0 = 8'h20;

  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_DECRYPT = 1;
  localparam int CTRL_XOR = 2;
  localparam int CTRL_AUTO = 3;
  localparam int CTRL_IRQ_EN = 4;
  // status register fields
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;

  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [8:0] OP_CYCLES = 9'd375;
  localparam logic [3:0] NUM_ROUNDS = 4'd10;
  localparam logic [7:0] RCON_FIRST = 8'h01;
  localparam logic [7:0] RCON_LAST = 8'h36;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    BCE_IDLE = 2'b00,
    BCE_EXPAND = 2'b01,
    BCE_ROUND = 2'b11,
    BCE_WAIT = 2'b10
  } bce_state_t;

  function automatic logic [7:0] xtime(input logic [7:0] a);
    xtime = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
  endfunction : xtime

  // inverse of xtime, used to walk the round constant backwards
  function automatic logic [7:0] xdiv(input logic [7:0] a);
    xdiv = a[0] ? (((a ^ 8'h1b) >> 1) | 8'h80) : (a >> 1);
  endfunction : xdiv

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] s;
    p = 8'h00;
    s = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ s;
      s = xtime(s);
    end
    gmul = p;
  endfunction : gmul

  // field inverse as x^254; zero maps to zero
  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] r;
    logic [7:0] s;
    r = 8'h01;
    s = x;
    for (int i = 1; i < 8; i++) begin
      s = gmul(s, s);
      r = gmul(r, s);
    end
    ginv = r;
  endfunction : ginv

  function automatic logic [7:0] rotl8(input logic [7:0] a, input int n);
    rotl8 = (a << n) | (a >> (8 - n));
  endfunction : rotl8

  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] b;
    b = ginv(x);
    sbox = b ^ rotl8(b, 1) ^ rotl8(b, 2) ^ rotl8(b, 3) ^ rotl8(b, 4) ^ 8'h63;
  endfunction : sbox

  function automatic logic [7:0] isbox(input logic [7:0] x);
    isbox = ginv(rotl8(x, 1) ^ rotl8(x, 3) ^ rotl8(x, 6) ^ 8'h05);
  endfunction : isbox

  function automatic logic [31:0] sub_word(input logic [31:0] w);
    sub_word = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction : sub_word

  function automatic logic [7:0] byte_of(input logic [127:0] s, input int i);
    byte_of = s[127 - 8 * i -: 8];
  endfunction : byte_of

endpackage : bce_pkg

/* File: bce_core_if.sv */
// block cipher engine: carrier between register front end and round core
// assumes one clock; start is a one-cycle pulse sampled with key and block
`timescale 1ns/1ps
`default_nettype none
interface bce_core_if;
  logic start;
  logic decrypt;
  logic [127:0] key;
  logic [127:0] din;
  logic [127:0] dout;
  logic done;
  logic busy;
  modport core (input start, input decrypt, input key, input din,
                output dout, output done, output busy);
  modport ctl (output start, output decrypt, output key, output din,
               input dout, input done, input busy);
endinterface : bce_core_if
`default_nettype wire

/* File: bce_core.sv */
// block cipher engine: iterative round core, one round per clock
// assumes start only while idle; result and done pulse appear a fixed count after start
`timescale 1ns/1ps
`default_nettype none
module bce_core (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  bce_core_if.core bus
);

  bce_pkg::bce_state_t state_r;
  logic [127:0] st_r;
  logic [127:0] rk_r;
  logic [7:0] rcon_r;
  logic [3:0] round_r;
  logic [8:0] cyc_r;
  logic dec_r;
  logic done_r;
  logic [127:0] nk_fwd;
  logic [127:0] nk_back;
  logic [127:0] enc_nxt;
  logic [127:0] dec_nxt;

  ////////////////////////////////////////////////////////////////////////
  // key schedule, forwards and backwards
  always_comb begin
    logic [31:0] t;
    logic [31:0] w3;
    t = bce_pkg::sub_word({rk_r[23:0], rk_r[31:24]}) ^ {rcon_r, 24'h000000};
    w3 = rk_r[31:0] ^ rk_r[63:32];
    nk_fwd[127:96] = rk_r[127:96] ^ t;
    nk_fwd[95:64] = rk_r[95:64] ^ nk_fwd[127:96];
    nk_fwd[63:32] = rk_r[63:32] ^ nk_fwd[95:64];
    nk_fwd[31:0] = rk_r[31:0] ^ nk_fwd[63:32];
    nk_back[31:0] = w3;
    nk_back[63:32] = rk_r[63:32] ^ rk_r[95:64];
    nk_back[95:64] = rk_r[95:64] ^ rk_r[127:96];
    nk_back[127:96] = rk_r[127:96] ^ bce_pkg::sub_word({w3[23:0], w3[31:24]})
                      ^ {rcon_r, 24'h000000};
  end

  ////////////////////////////////////////////////////////////////////////
  // forward and inverse rounds on the whole block
  always_comb begin
    logic [127:0] sh;
    logic [127:0] ish;
    logic [7:0] a0, a1, a2, a3;
    sh = '0;
    ish = '0;
    {a0, a1, a2, a3} = 32'h00000000;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        sh[127 - 8 * (r + 4 * c) -: 8] =
          bce_pkg::sbox(bce_pkg::byte_of(st_r, r + 4 * ((c + r) % 4)));
        ish[127 - 8 * (r + 4 * c) -: 8] =
          bce_pkg::isbox(bce_pkg::byte_of(st_r, r + 4 * ((c + 4 - r) % 4)));
      end
    end
    ish = ish ^ nk_back;
    enc_nxt = sh;
    dec_nxt = ish;
    for (int c = 0; c < 4; c++) begin
      a0 = bce_pkg::byte_of(sh, 4 * c);
      a1 = bce_pkg::byte_of(sh, 4 * c + 1);
      a2 = bce_pkg::byte_of(sh, 4 * c + 2);
      a3 = bce_pkg::byte_of(sh, 4 * c + 3);
      if (round_r != bce_pkg::NUM_ROUNDS) begin
        enc_nxt[127 - 32 * c -: 32] = {
          bce_pkg::xtime(a0) ^ bce_pkg::xtime(a1) ^ a1 ^ a2 ^ a3,
          a0 ^ bce_pkg::xtime(a1) ^ bce_pkg::xtime(a2) ^ a2 ^ a3,
          a0 ^ a1 ^ bce_pkg::xtime(a2) ^ bce_pkg::xtime(a3) ^ a3,
          bce_pkg::xtime(a0) ^ a0 ^ a1 ^ a2 ^ bce_pkg::xtime(a3)};
      end
      a0 = bce_pkg::byte_of(ish, 4 * c);
      a1 = bce_pkg::byte_of(ish, 4 * c + 1);
      a2 = bce_pkg::byte_of(ish, 4 * c + 2);
      a3 = bce_pkg::byte_of(ish, 4 * c + 3);
      if (round_r != bce_pkg::NUM_ROUNDS) begin
        dec_nxt[127 - 32 * c -: 32] = {
          bce_pkg::gmul(a0, 8'h0e) ^ bce_pkg::gmul(a1, 8'h0b) ^
          bce_pkg::gmul(a2, 8'h0d) ^ bce_pkg::gmul(a3, 8'h09),
          bce_pkg::gmul(a0, 8'h09) ^ bce_pkg::gmul(a1, 8'h0e) ^
          bce_pkg::gmul(a2, 8'h0b) ^ bce_pkg::gmul(a3, 8'h0d),
          bce_pkg::gmul(a0, 8'h0d) ^ bce_pkg::gmul(a1, 8'h09) ^
          bce_pkg::gmul(a2, 8'h0e) ^ bce_pkg::gmul(a3, 8'h0b),
          bce_pkg::gmul(a0, 8'h0b) ^ bce_pkg::gmul(a1, 8'h0d) ^
          bce_pkg::gmul(a2, 8'h09) ^ bce_pkg::gmul(a3, 8'h0e)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer; the rounds finish early and the wait pads to a fixed latency
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r <= bce_pkg::BCE_IDLE;
      st_r <= '0;
      rk_r <= '0;
      rcon_r <= bce_pkg::RCON_FIRST;
      round_r <= 4'h0;
      dec_r <= 1'b0;
    end else begin
      unique case (state_r)
        bce_pkg::BCE_IDLE: begin
          if (bus.start) begin
            dec_r <= bus.decrypt;
            rk_r <= bus.key;
            rcon_r <= bce_pkg::RCON_FIRST;
            // decryption whitens with the last round key once expansion is over
            st_r <= bus.decrypt ? bus.din : bus.din ^ bus.key;
            round_r <= bus.decrypt ? 4'h0 : 4'h1;
            state_r <= bus.decrypt ? bce_pkg::BCE_EXPAND : bce_pkg::BCE_ROUND;
          end
        end
        bce_pkg::BCE_EXPAND: begin
          // decryption needs the last round key first
          rk_r <= nk_fwd;
          rcon_r <= bce_pkg::xtime(rcon_r);
          round_r <= round_r + 4'h1;
          if (round_r == bce_pkg::NUM_ROUNDS - 4'h1) begin
            st_r <= st_r ^ nk_fwd;
            rcon_r <= bce_pkg::RCON_LAST;
            round_r <= 4'h1;
            state_r <= bce_pkg::BCE_ROUND;
          end
        end
        bce_pkg::BCE_ROUND: begin
          if (dec_r) begin
            st_r <= dec_nxt;
            rk_r <= nk_back;
            rcon_r <= bce_pkg::xdiv(rcon_r);
          end else begin
            st_r <= enc_nxt ^ nk_fwd;
            rk_r <= nk_fwd;
            rcon_r <= bce_pkg::xtime(rcon_r);
          end
          round_r <= round_r + 4'h1;
          if (round_r == bce_pkg::NUM_ROUNDS) state_r <= bce_pkg::BCE_WAIT;
        end
        bce_pkg::BCE_WAIT: begin
          if (done_r) state_r <= bce_pkg::BCE_IDLE;
        end
      endcase
    end
  end

  // latency counter from the start pulse
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cyc_r <= 9'd0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (state_r == bce_pkg::BCE_IDLE) begin
        cyc_r <= bus.start ? 9'd1 : 9'd0;
      end else if (!done_r) begin
        cyc_r <= cyc_r + 9'd1;
        done_r <= (cyc_r == bce_pkg::OP_CYCLES - 9'd1);
      end
    end
  end

  assign bus.dout = st_r;
  assign bus.done = done_r;
  assign bus.busy = (state_r != bce_pkg::BCE_IDLE);

endmodule : bce_core
`default_nettype wire

/* File: bce_asserts.sv */
// block cipher engine: timing and handshake checker on the top ports
// assumes it is bound to bce_top; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module bce_asserts (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic o_irq,
  input wire logic o_dma_trig
);
  logic [7:0] wa_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  logic auto_r;
  logic irq_en_r;
  logic [8:0] cnt_r;
  logic go;
  assign go = (wa_r == bce_pkg::OFF_CTRL && ws_r[0] && wd_r[bce_pkg::CTRL_START])
    || (auto_r && wa_r == bce_pkg::OFF_STATE3 && ws_r[3]);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk) begin
    if (i_s_axi_awvalid && o_s_axi_awready) wa_r <= i_s_axi_awaddr;
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      wd_r <= i_s_axi_wdata;
      ws_r <= i_s_axi_wstrb;
    end
  end
  // model op starts one edge after the write answer; busy starts dropped
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt_r <= 9'h000;
      auto_r <= 1'b0;
      irq_en_r <= 1'b0;
    end else begin
      if (cnt_r != 9'h000) cnt_r <= cnt_r - 9'h001;
      else if ($rose(o_s_axi_bvalid) && go) cnt_r <= 9'h178;
      if ($rose(o_s_axi_bvalid) && wa_r == bce_pkg::OFF_CTRL && ws_r[0]) begin
        auto_r <= wd_r[bce_pkg::CTRL_AUTO];
        irq_en_r <= wd_r[bce_pkg::CTRL_IRQ_EN];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_trig_count: assert property (o_dma_trig == (cnt_r == 9'h001))
    else $error("completion trigger off its cycle");
  a_trig_pulse: assert property (o_dma_trig |=> !o_dma_trig)
    else $error("completion trigger longer than one cycle");
  a_irq_follow: assert property (o_dma_trig |-> o_irq == irq_en_r)
    else $error("interrupt does not follow its enable at completion");
  a_busy_zero: assert property (i_s_axi_arvalid && o_s_axi_arready && cnt_r > 9'h002
    && i_s_axi_araddr[7:4] == 4'h1 |=> o_s_axi_rdata == 32'h0)
    else $error("state readable while busy");
  a_b_after: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
    && o_s_axi_wready |=> ##1 o_s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write answer dropped");
  a_r_after: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  a_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read answer dropped");
  a_aw_block: assert property (i_s_axi_awvalid && o_s_axi_awready |=> !o_s_axi_awready [*2])
    else $error("address ready before answer done");
  a_reset_quiet: assert property (disable iff (1'b0) i_reset |=> !o_s_axi_bvalid
    && !o_s_axi_rvalid && !o_s_axi_awready && !o_dma_trig && !o_irq)
    else $error("outputs active after reset");
endmodule : bce_asserts
`default_nettype wire

/* File: bce_host.sv */
// block cipher engine: bus master model standing in for the processor
// assumes one clock; the bench calls wr and rd one at a time
`timescale 1ns/1ps
`default_nettype none
module bce_host (
  input wire logic i_sys_clk,
  input wire logic i_awready,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  input wire logic i_arready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  input wire logic i_rvalid,
  output logic [7:0] o_awaddr,
  output logic o_awvalid,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wvalid,
  output logic o_bready,
  output logic [7:0] o_araddr,
  output logic o_arvalid,
  output logic o_rready
);
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid} = '0;
    {o_bready, o_araddr, o_arvalid, o_rready} = '0;
  end
  // released address and data lines show the inverse of the last value so stale data cannot match; wstrb keeps its value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge i_sys_clk);
    o_awaddr <= a;
    o_wdata <= d;
    o_wstrb <= s;
    o_awvalid <= 1'b1;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
    end while (i_bvalid !== 1'b1);
    r = i_bresp;
    o_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_sys_clk);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
      end
    end while (i_rvalid !== 1'b1);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
  endtask : rd
endmodule : bce_host
`default_nettype wire

/* File: bce_top_test.sv */
// block cipher engine: self-checking bench on known cipher vectors
// assumes bce_top, the bce_host model and the bce_asserts checker
`timescale 1ns/1ps
`default_nettype none
module bce_top_test;
  typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic [1:0] rs;} bce_row_t;
  localparam logic [1:0] OK = bce_pkg::RESP_OKAY;
  localparam logic [1:0] ER = bce_pkg::RESP_SLVERR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, trig;
  int fail_count = 0;
  int compares = 0;
  logic [31:0] key[4] = '{32'h03020100, 32'h07060504, 32'h0b0a0908, 32'h0f0e0d0c};
  logic [31:0] pt[4] = '{32'h33221100, 32'h77665544, 32'hbbaa9988, 32'hffeeddcc};
  logic [31:0] ct[4] = '{32'hd8e0c469, 32'h30047b6a, 32'h80b7cdd8, 32'h5ac5b470};
  bce_row_t rows[12];
  bce_top i_dut (.i_sys_clk(clk), .i_reset(rst), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_irq(irq), .o_dma_trig(trig));
  bce_host i_host (.i_sys_clk(clk), .i_awready(awready), .i_wready(wready),
    .i_bresp(bresp), .i_bvalid(bvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rresp(rresp), .i_rvalid(rvalid), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .o_bready(bready),
    .o_araddr(araddr), .o_arvalid(arvalid), .o_rready(rready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] rs);
    logic [1:0] r;
    i_host.wr(a, d, s, r);
    chk({30'h0, r}, {30'h0, rs});
  endtask : wrc
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] rs);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, rs});
  endtask : rdc
  // bounded wait so a missing trigger shows as a mismatch, not a hang
  task automatic wait_trig();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (trig !== 1'b1 && n < 1000);
  endtask : wait_trig
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #(5000 * 8);
    fail_count++;
    print_verdict();
  end
  initial begin
    time t0;
    for (int k = 0; k < 4; k++) begin
      rows[k] = '{8'h20 + 8'(4 * k), key[k], key[k], OK};
      rows[4 + k] = '{8'h10 + 8'(4 * k), pt[k], pt[k], OK};
    end
    rows[8] = '{8'h00, 32'h10, 32'h10, OK};
    rows[9] = '{8'h04, 32'hff, 32'h0, OK};
    rows[10] = '{8'h30, 32'h1, 32'h0, ER};
    rows[11] = '{8'h12, 32'h1, 32'h0, ER};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wrc(rows[i].a, rows[i].wd, 4'hf, rows[i].rs);
      rdc(rows[i].a, rows[i].rd, rows[i].rs);
    end
    $display("test register rows done");
    wrc(8'h00, 32'h11, 4'hf, OK);
    t0 = $time;
    rdc(8'h04, 32'h2, OK);
    rdc(8'h10, 32'h0, OK);
    wait_trig();
    chk(32'(($time - t0) / 8), 32'd376);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    chk({31'h0, trig}, 32'h0);
    for (int k = 0; k < 4; k++) rdc(8'h10 + 8'(4 * k), ct[k], OK);
    rdc(8'h04, 32'h1, OK);
    $display("test encrypt done");
    wrc(8'h00, 32'h13, 4'hf, OK);
    rdc(8'h04, 32'h2, OK);
    chk({31'h0, irq}, 32'h0);
    wait_trig();
    chk({31'h0, irq}, 32'h1);
    for (int k = 0; k < 4; k++) rdc(8'h10 + 8'(4 * k), pt[k], OK);
    wrc(8'h00, 32'h02, 4'hf, OK);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test decrypt done");
    wrc(8'h00, 32'h0c, 4'hf, OK);
    wrc(8'h10, 32'hffffffff, 4'hf, OK);
    rdc(8'h10, ~pt[0], OK);
    wrc(8'h14, 32'h0000ff00, 4'h1, OK);
    rdc(8'h14, pt[1], OK);
    wrc(8'h10, 32'hffffffff, 4'hf, OK);
    wrc(8'h1c, 32'h0, 4'hf, OK);
    t0 = $time;
    wrc(8'h20, 32'h0, 4'hf, OK);
    wait_trig();
    chk(32'(($time - t0) / 8), 32'd376);
    chk({31'h0, irq}, 32'h0);
    for (int k = 0; k < 4; k++) rdc(8'h10 + 8'(4 * k), ct[k], OK);
    rdc(8'h20, key[0], OK);
    $display("test xor auto start done");
    wrc(8'h00, 32'h11, 4'hf, OK);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h0, OK);
    rdc(8'h04, 32'h0, OK);
    $display("test reset done");
    print_verdict();
  end
endmodule : bce_top_test
bind bce_top bce_asserts i_chk (.i_sys_clk, .i_reset, .i_s_axi_awaddr, .i_s_axi_awvalid,
  .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
  .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
  .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready, .o_irq, .o_dma_trig);
`default_nettype wire
